// [hw/kpi_top.sv]
// Pin interrupt unit: eight pin sources, shared detection flag, register port.
// Assumes pins are asynchronous levels and the register master is on CLK_I.
//
// Added by the designer: the strobed register port.

module kpi_top (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  input  wire logic [7:0]  KEY_PIN_I,
  input  wire logic        STOP_MODE_I,
  output logic             KEY_IRQ_O,
  output logic             EVT_IRQ_O,
  output logic             WAKE_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic       mode_r;
  logic       ie_r;
  logic       flag_r;
  logic       armed_r;
  logic [7:0] pin_en_r;
  logic [7:0] pin_pol_r;
  logic [7:0] evt_stat_r;
  logic [7:0] evt_stat_nxt;
  logic [7:0] evt_mask_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] pin_sync;
  logic [7:0] pin_asserted;
  logic [7:0] pin_edge;
  logic [7:0] raw_asserted;
  logic       any_asserted;
  logic       any_edge;
  logic       edge_evt;
  logic       level_evt;
  logic       flag_set;
  logic       flag_clr;
  logic       sc_wr;
  logic       pe_wr;
  logic       es_wr;
  logic       stat_wr;
  logic       mask_wr;
  logic       ack_wr;

  // ----------------------------------------------------------------
  // Pin synchronisation and per-pin sense
  // ----------------------------------------------------------------
  kpi_sync2 #(
    .W (kpi_pkg::PIN_N)
  ) u_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .async_i   (KEY_PIN_I),
    .sync_o    (pin_sync)
  );

  // Eight identical sources share the one flag
  for (genvar g = 0; g < kpi_pkg::PIN_N; g++) begin : g_pin
    kpi_pin_det u_det (
      .clk_i      (CLK_I),
      .reset_n_i  (RESET_N_I),
      .pin_i      (pin_sync[g]),
      .en_i       (pin_en_r[g]),
      .pol_i      (pin_pol_r[g]),
      .asserted_o (pin_asserted[g]),
      .edge_o     (pin_edge[g])
    );
  end

  assign any_asserted = |pin_asserted;
  assign any_edge     = |pin_edge;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign sc_wr   = WR_I && (ADDR_I == kpi_pkg::KEY_STATUS_CONTROL_ADDR);
  assign pe_wr   = WR_I && (ADDR_I == kpi_pkg::KEY_PIN_ENABLES_ADDR);
  assign es_wr   = WR_I && (ADDR_I == kpi_pkg::KEY_POLARITY_SELECT_ADDR);
  assign stat_wr = WR_I && (ADDR_I == kpi_pkg::EVT_STATUS_ADDR);
  assign mask_wr = WR_I && (ADDR_I == kpi_pkg::EVT_MASK_ADDR);
  assign ack_wr  = sc_wr && WDATA_I[kpi_pkg::FLAG_ACKNOWLEDGE_BIT];

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  // Flag and acknowledge positions are not stored; upper nibble is dropped
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mode_r <= kpi_pkg::KEY_STATUS_CONTROL_RST[kpi_pkg::DETECT_LEVEL_MODE_BIT];
      ie_r   <= kpi_pkg::KEY_STATUS_CONTROL_RST[kpi_pkg::INTERRUPT_MASK_ENABLE_BIT];
    end else if (sc_wr) begin
      mode_r <= WDATA_I[kpi_pkg::DETECT_LEVEL_MODE_BIT];
      ie_r   <= WDATA_I[kpi_pkg::INTERRUPT_MASK_ENABLE_BIT];
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_en_r <= kpi_pkg::KEY_PIN_ENABLES_RST;
    end else if (pe_wr) begin
      pin_en_r <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_pol_r <= kpi_pkg::KEY_POLARITY_SELECT_RST;
    end else if (es_wr) begin
      pin_pol_r <= WDATA_I;
    end
  end

  // ----------------------------------------------------------------
  // Edge arming
  // ----------------------------------------------------------------
  // Starts disarmed so a pin already asserted at enable gives no edge
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      armed_r <= 1'b0;
    end else if (edge_evt) begin
      armed_r <= 1'b0;
    end else if (!any_asserted) begin
      armed_r <= 1'b1;
    end
  end

  assign edge_evt  = armed_r && any_edge;
  assign level_evt = mode_r && any_asserted;

  // ----------------------------------------------------------------
  // Detection flag
  // ----------------------------------------------------------------
  assign flag_set = edge_evt || level_evt;
  // Level mode holds the flag while any enabled pin is asserted
  assign flag_clr = ack_wr && (!mode_r || !any_asserted);

  // Set wins so an event in the ack cycle is kept
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      flag_r <= kpi_pkg::KEY_STATUS_CONTROL_RST[kpi_pkg::DETECTION_FLAG_BIT];
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  assign KEY_IRQ_O = flag_r && ie_r;

  // ----------------------------------------------------------------
  // Wake-up
  // ----------------------------------------------------------------
  // Stop path looks at raw pins because no clock runs to synchronise them
  assign raw_asserted = pin_en_r & ~(KEY_PIN_I ^ pin_pol_r);
  assign WAKE_O = KEY_IRQ_O || (STOP_MODE_I && ie_r && (|raw_asserted));

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  always_comb begin
    evt_stat_nxt = evt_stat_r;
    if (stat_wr) begin
      evt_stat_nxt = evt_stat_r & ~WDATA_I;
    end
    if (edge_evt) begin
      evt_stat_nxt[kpi_pkg::EVT_EDGE_BIT] = 1'b1;
    end
    if (level_evt) begin
      evt_stat_nxt[kpi_pkg::EVT_LEVEL_BIT] = 1'b1;
    end
    evt_stat_nxt[7:2] = 6'h00;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      evt_stat_r <= kpi_pkg::EVT_STATUS_RST;
    end else begin
      evt_stat_r <= evt_stat_nxt;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      evt_mask_r <= kpi_pkg::EVT_MASK_RST;
    end else if (mask_wr) begin
      evt_mask_r <= {6'h00, WDATA_I[1:0]};
    end
  end

  assign EVT_IRQ_O = |(evt_stat_r & evt_mask_r);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Data stand only in the cycle after the read strobe; otherwise zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        kpi_pkg::KEY_STATUS_CONTROL_ADDR: begin
          rdata_nxt = {4'h0, flag_r, 1'b0, ie_r, mode_r};
        end
        kpi_pkg::KEY_PIN_ENABLES_ADDR: begin
          rdata_nxt = pin_en_r;
        end
        kpi_pkg::KEY_POLARITY_SELECT_ADDR: begin
          rdata_nxt = pin_pol_r;
        end
        kpi_pkg::EVT_STATUS_ADDR: begin
          rdata_nxt = evt_stat_r;
        end
        kpi_pkg::EVT_MASK_ADDR: begin
          rdata_nxt = evt_mask_r;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdata_r <= kpi_pkg::RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_O = rdata_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  sequence s_sc_read;
    RD_I && (ADDR_I == kpi_pkg::KEY_STATUS_CONTROL_ADDR);
  endsequence

  sequence s_edge_hit;
    edge_evt && !mode_r;
  endsequence

  sequence s_ack_level_busy;
    ack_wr && mode_r && any_asserted;
  endsequence

  a_edge_sets_flag: assert property (
    s_edge_hit |=> flag_r)
    else $error("edge did not set flag");

  a_fall_edge_seen: assert property (
    armed_r && pin_en_r[7] && !pin_pol_r[7] && $past(pin_sync[7]) && !pin_sync[7]
    |=> flag_r)
    else $error("falling edge on pin 7 missed");

  a_rise_edge_seen: assert property (
    armed_r && pin_en_r[0] && pin_pol_r[0] && !$past(pin_sync[0]) && pin_sync[0]
    |=> flag_r)
    else $error("rising edge on pin 0 missed");

  a_no_double_edge: assert property (
    edge_evt |=> !edge_evt)
    else $error("second edge before inputs went inactive");

  a_level_sets: assert property (
    level_evt |=> flag_r [*1] ##1 (flag_r || !$past(any_asserted)))
    else $error("held level did not keep flag");

  a_ack_clears_edge: assert property (
    ack_wr && !mode_r && !edge_evt |=> !flag_r)
    else $error("ack did not clear flag in edge mode");

  a_level_holds_ack: assert property (
    s_ack_level_busy |=> flag_r)
    else $error("flag cleared while input asserted");

  a_flag_read_only: assert property (
    sc_wr && WDATA_I[kpi_pkg::DETECTION_FLAG_BIT] && !flag_r && !flag_set |=> !flag_r)
    else $error("write set the flag");

  a_irq_masked: assert property (
    !ie_r |-> !KEY_IRQ_O)
    else $error("request raised while disabled");

  a_irq_follows: assert property (
    flag_r && ie_r && flag_clr && !flag_set |=> !KEY_IRQ_O ##1 !KEY_IRQ_O || flag_r)
    else $error("request did not drop after flag cleared");

  a_rsvd_zero: assert property (
    s_sc_read |=> RDATA_O[7:4] == 4'h0 && RDATA_O[3] == $past(flag_r))
    else $error("reserved bits nonzero or flag misread");

  a_disabled_quiet: assert property (
    pin_en_r == 8'h00 |-> !any_asserted && !edge_evt)
    else $error("disabled pins produced a detection");

  a_irq_when_set: assert property (
    flag_r && ie_r |-> KEY_IRQ_O)
    else $error("request missing while flag and enable set");

  a_edge_mode_only: assert property (
    !mode_r && !flag_r && !edge_evt |=> !flag_r)
    else $error("flag set without an edge in edge-only mode");

  a_rearm_idle: assert property (
    !any_asserted |=> armed_r)
    else $error("detector not armed after inputs went inactive");

  a_wake_on_irq: assert property (
    KEY_IRQ_O |-> WAKE_O)
    else $error("request did not raise wake");

  a_stop_wake: assert property (
    STOP_MODE_I && ie_r && (|(pin_en_r & ~(KEY_PIN_I ^ pin_pol_r))) |-> WAKE_O)
    else $error("asserted pin in stop did not raise wake");

endmodule

// [hw/kpi_pkg.sv]
// Package: register map, field positions, reset values for the pin interrupt unit.
// Assumes an 8-bit register port with 16-bit byte addresses.

package kpi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_N  = 8;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] KEY_STATUS_CONTROL_ADDR  = 16'h003c;
  localparam logic [15:0] KEY_PIN_ENABLES_ADDR     = 16'h307c;
  localparam logic [15:0] KEY_POLARITY_SELECT_ADDR = 16'h307d;
  localparam logic [15:0] EVT_STATUS_ADDR          = 16'h3080;
  localparam logic [15:0] EVT_MASK_ADDR            = 16'h3081;

  // ----------------------------------------------------------------
  // Status and control field positions
  // ----------------------------------------------------------------
  localparam int unsigned DETECT_LEVEL_MODE_BIT     = 0;
  localparam int unsigned INTERRUPT_MASK_ENABLE_BIT = 1;
  localparam int unsigned FLAG_ACKNOWLEDGE_BIT      = 2;
  localparam int unsigned DETECTION_FLAG_BIT        = 3;

  // Event status and mask field positions
  localparam int unsigned EVT_EDGE_BIT  = 0;
  localparam int unsigned EVT_LEVEL_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_STATUS_CONTROL_RST  = 8'h00;
  localparam logic [7:0] KEY_PIN_ENABLES_RST     = 8'h00;
  localparam logic [7:0] KEY_POLARITY_SELECT_RST = 8'h00;
  localparam logic [7:0] EVT_STATUS_RST          = 8'h00;
  localparam logic [7:0] EVT_MASK_RST            = 8'h00;
  localparam logic [7:0] RDATA_RST               = 8'h00;

endpackage

// [hw/kpi_sync2.sv]
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; no bus coherency across bits.

module kpi_sync2 #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // ----------------------------------------------------------------
  // Capture chain; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// [hw/kpi_pin_det.sv]
// One input pin of the pin interrupt unit: asserted level and edge sense.
// Assumes the pin level is already synchronised to the bus clock.

module kpi_pin_det (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic pin_i,
  input  wire logic en_i,
  input  wire logic pol_i,
  output logic      asserted_o,
  output logic      edge_o
);

  logic prev_r;

  // ----------------------------------------------------------------
  // One bus cycle of history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin_i;
    end
  end

  // ----------------------------------------------------------------
  // Sense
  // ----------------------------------------------------------------
  // Polarity 0 asserts low, 1 asserts high
  assign asserted_o = en_i && (pin_i == pol_i);
  // Deasserted last cycle, asserted now: fall for 0, rise for 1
  assign edge_o     = asserted_o && (prev_r != pol_i);

endmodule

// [verification/kpi_keys.sv]
// Behavioural switch bank standing on the unit's input pins.
// Assumes the bench asks for pin levels on the bus clock.
module kpi_keys (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] want_i,
  output logic      [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] lag_r [3];

  always_ff @(posedge clk_i) begin
    lag_r[0] <= want_i;
    lag_r[1] <= lag_r[0];
    lag_r[2] <= lag_r[1];
  end

  // Slow keys close late; the unit must not rely on prompt pins
  assign pin_o = slow_i ? lag_r[2] : lag_r[0];
endmodule

// [verification/kpi_top_tb.sv]
// Self-checking bench for the pin interrupt unit.
// Assumes the register port answers one cycle after a read strobe.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module kpi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr  = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  idle  = 8'hf0;
  logic [7:0]  want  = 8'hf0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        stop  = 1'b0;
  logic        slow  = 1'b0;
  logic        rd_q  = 1'b0;
  logic [7:0]  pins;
  logic [7:0]  rdata;
  logic [7:0]  e_v;
  logic        key_irq;
  logic        evt_irq;
  logic        wake;
  logic [7:0]  expq [$];
  int          errors = 0;
  int          check_count = 0;
  int          cyc_n = 0;
  integer      seed = 32'h6f7352da;

  always #2 clk = ~clk;

  kpi_keys kpi_keys_i (.clk_i(clk), .slow_i(slow), .want_i(want), .pin_o(pins));

  kpi_top kpi_top_i (
    .CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .KEY_PIN_I(pins), .STOP_MODE_I(stop), .KEY_IRQ_O(key_irq),
    .EVT_IRQ_O(evt_irq), .WAKE_O(wake)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // Pin levels settle through the partner, two sync flops and the flag
  task automatic press(input logic [7:0] v);
    @(posedge clk);
    want <= v;
    cyc(10);
  endtask

  // ----------------------------------------------------------------
  // Read monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_q <= rd;
    cyc_n++;
    if (rd_q) begin
      e_v = expq.pop_front();
      `CHK("rdata", e_v, rdata)
    end else if (rst_n) begin
      `CHK("rdata idle", 8'h00, rdata)
    end
    if (cyc_n == 20000) begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(16'h003c, 8'h00);
    rd_reg(16'h307c, 8'h00);
    rd_reg(16'h307d, 8'h00);
    rd_reg(16'h1234, 8'h00);
    wr_reg(16'h003c, 8'hff);
    rd_reg(16'h003c, 8'h03);
    wr_reg(16'h003c, 8'h00);
    wr_reg(16'h307d, 8'h0f);
    wr_reg(16'h307c, 8'hff);
    wr_reg(16'h003c, 8'h04);
    wr_reg(16'h003c, 8'h02);
    wr_reg(16'h3081, 8'h01);
    rd_reg(16'h307d, 8'h0f);
    rd_reg(16'h3081, 8'h01);
    cyc(4);
    `CHK("irq idle", 1'b0, key_irq)
    for (int i = 0; i < 8; i++) begin
      slow <= 1'($random(seed));
      press(idle ^ (8'h01 << i));
      `CHK("irq set", 1'b1, key_irq)
      rd_reg(16'h003c, 8'h0a);
      press(idle);
      `CHK("irq held", 1'b1, key_irq)
      wr_reg(16'h003c, 8'h06);
      cyc(1);
      `CHK("irq ack", 1'b0, key_irq)
    end
    // Second key while the first is held must not count
    press(idle ^ 8'h01);
    wr_reg(16'h003c, 8'h06);
    press(idle ^ 8'h03);
    `CHK("disarmed", 1'b0, key_irq)
    press(idle ^ 8'h02);
    `CHK("still disarmed", 1'b0, key_irq)
    press(idle);
    press(idle ^ 8'h02);
    `CHK("rearmed", 1'b1, key_irq)
    `CHK("evt irq", 1'b1, evt_irq)
    rd_reg(16'h3080, 8'h01);
    wr_reg(16'h3080, 8'h01);
    cyc(1);
    `CHK("evt clear", 1'b0, evt_irq)
    press(idle);
    wr_reg(16'h003c, 8'h04);
    press(idle ^ 8'h80);
    `CHK("masked", 1'b0, key_irq)
    rd_reg(16'h003c, 8'h08);
    wr_reg(16'h003c, 8'h02);
    cyc(1);
    `CHK("unmasked", 1'b1, key_irq)
    press(idle);
    wr_reg(16'h003c, 8'h06);
    // Noise on excluded pins only
    wr_reg(16'h307c, 8'h01);
    for (int i = 0; i < 6; i++) begin
      press(idle ^ (8'($random(seed)) & 8'hfe));
    end
    `CHK("disabled", 1'b0, key_irq)
    press(idle);
    wr_reg(16'h307c, 8'hff);
    wr_reg(16'h003c, 8'h07);
    press(idle ^ 8'h10);
    wr_reg(16'h003c, 8'h07);
    cyc(2);
    `CHK("level held", 1'b1, key_irq)
    rd_reg(16'h003c, 8'h0b);
    press(idle);
    wr_reg(16'h003c, 8'h07);
    cyc(1);
    `CHK("level clear", 1'b0, key_irq)
    rd_reg(16'h3080, 8'h03);
    wr_reg(16'h003c, 8'h06);
    @(posedge clk);
    slow <= 1'b0;
    stop <= 1'b1;
    want <= idle ^ 8'h20;
    cyc(1);
    `CHK("wake", 1'b1, wake)
    cyc(8);
    `CHK("wake irq", 1'b1, key_irq)
    @(posedge clk);
    stop <= 1'b0;
    want <= idle;
    cyc(1);
    `CHK("wake run", 1'b1, wake)
    cyc(4);
    wr_reg(16'h003c, 8'h04);
    cyc(1);
    `CHK("wake acked", 1'b0, wake)
    @(posedge clk);
    stop <= 1'b1;
    want <= idle ^ 8'h20;
    cyc(2);
    `CHK("wake off", 1'b0, wake)
    @(posedge clk);
    stop <= 1'b0;
    want <= idle;
    cyc(4);
    close_out();
  end
endmodule
